// File: mch_dev.sv
// Purpose: Monitor channel handshake controller with an AXI4-Lite register slave.
// Assumes: Peer makes link clock and frame sync; both are sampled through two flip-flops.
// Notes:   One or two channels; the handshake itself has no timeout anywhere.
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module mch_dev (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Interrupt
   output logic             irq,
   // Backplane link
   mch_link_if.dev          link
);

   logic [2:0]              sy1_q;
   logic [2:0]              sy2_q;
   logic                    lclk_p_q;
   logic                    rise;
   logic                    fall;
   logic [5:0]              ctrl_q, ctrl_d;
   logic [7:0]              txb_q [2];
   logic [7:0]              txb_d [2];
   logic [7:0]              rxb_q [2];
   logic [7:0]              rxb_d [2];
   logic [7:0]              stat_q, stat_d;
   logic [7:0]              mask_q, mask_d;
   logic [1:0]              unread_q, unread_d;
   mch_pkg::mch_chan_s      ch_q [2];
   mch_pkg::mch_chan_s      ch_d [2];
   logic [4:0]              idx_q, idx_d;
   logic [23:0]             sh_q, sh_d;
   logic [23:0]             ofr;
   logic                    done_q, done_d;
   logic                    dn_q, dn_d;
   logic                    aw_q, aw_d;
   logic [7:0]              awa_q, awa_d;
   logic                    w_q, w_d;
   logic [31:0]             wd_q, wd_d;
   logic                    ws_q, ws_d;
   logic                    bv_q, bv_d;
   logic [1:0]              br_q, br_d;
   logic                    rv_q, rv_d;
   logic [31:0]             rd_q, rd_d;
   logic [1:0]              rr_q, rr_d;
   logic [1:0]              en;
   logic [1:0]              act;

   // Link pins come from the peer's domain; only the second stage is read.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sy1_q    <= 3'h0;
         sy2_q    <= 3'h0;
         lclk_p_q <= 1'b0;
      end else begin
         sy1_q    <= {link.up, link.fsync, link.lclk};
         sy2_q    <= sy1_q;
         lclk_p_q <= sy2_q[mch_pkg::L_CLK];
      end
   end

   assign rise = sy2_q[mch_pkg::L_CLK] & ~lclk_p_q;
   assign fall = ~sy2_q[mch_pkg::L_CLK] & lclk_p_q;

   always_comb begin
      en[0] = 1'b1;
      en[1] = ctrl_q[mch_pkg::C_TERM];
      ofr   = 24'hFF_FFFF;
      for (int c = 0; c < 2; c++) begin
         // A channel that does not exist leaves its slot idle for other devices.
         ofr[c*mch_pkg::CH_STRIDE +: 8]                 = en[c] ? txb_q[c] : 8'hFF;
         ofr[c*mch_pkg::CH_STRIDE + mch_pkg::POS_MX]    = ch_q[c].mx;
         ofr[c*mch_pkg::CH_STRIDE + mch_pkg::POS_MR]    = ch_q[c].mr;
         act[c] = en[c] & (~ch_q[c].mx | ~ch_q[c].mr | ch_q[c].busy);
      end
   end

   always_comb begin
      logic [3:0] ev;
      logic [7:0] set;
      logic [7:0] clr;
      logic [1:0] rdclr;
      logic       wr;
      ev       = 4'h0;
      set      = 8'h00;
      clr      = 8'h00;
      rdclr    = 2'h0;
      wr       = aw_q & w_q & ~bv_q;
      ctrl_d   = ctrl_q;
      txb_d    = txb_q;
      rxb_d    = rxb_q;
      mask_d   = mask_q;
      ch_d     = ch_q;
      idx_d    = idx_q;
      sh_d     = sh_q;
      done_d   = 1'b0;
      dn_d     = dn_q;
      aw_d     = aw_q;
      awa_d    = awa_q;
      w_d      = w_q;
      wd_d     = wd_q;
      ws_d     = ws_q;
      bv_d     = bv_q;
      br_d     = br_q;
      rv_d     = rv_q;
      rd_d     = rd_q;
      rr_d     = rr_q;
      // Link bit timing: sample on the rise, drive on the fall.
      if (rise) begin
         if (sy2_q[mch_pkg::L_FS]) begin
            sh_d[0] = sy2_q[mch_pkg::L_DAT];
            idx_d   = 5'h1;
         end else if (idx_q <= mch_pkg::LAST_BIT) begin
            sh_d[idx_q] = sy2_q[mch_pkg::L_DAT];
            if (idx_q == mch_pkg::LAST_BIT) begin
               idx_d  = 5'h0;
               done_d = 1'b1;
            end else begin
               idx_d = idx_q + 5'h1;
            end
         end
      end
      if (fall) begin
         dn_d = (idx_q <= mch_pkg::LAST_BIT) ? ofr[idx_q] : 1'b1;
      end
      // Bus write: address and data are taken in either order.
      if (s_axi_awvalid && !aw_q) begin
         aw_d  = 1'b1;
         awa_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
         w_d  = 1'b1;
         wd_d = s_axi_wdata;
         ws_d = s_axi_wstrb[0];
      end
      if (bv_q && s_axi_bready) begin
         bv_d = 1'b0;
      end
      if (wr) begin
         aw_d = 1'b0;
         w_d  = 1'b0;
         bv_d = 1'b1;
         br_d = mch_pkg::RESP_OKAY;
         case ({awa_q[7:2], 2'h0})
            mch_pkg::A_CTRL:  if (ws_q) ctrl_d = wd_q[5:0];
            mch_pkg::A_TX0:   if (ws_q) txb_d[0] = wd_q[7:0];
            mch_pkg::A_TX1:   if (ws_q) txb_d[1] = wd_q[7:0];
            mch_pkg::A_STAT:  if (ws_q) clr = wd_q[7:0];
            mch_pkg::A_MASK:  if (ws_q) mask_d = wd_q[7:0];
            mch_pkg::A_RX0, mch_pkg::A_RX1, mch_pkg::A_GSTAT: br_d = mch_pkg::RESP_OKAY;
            default:          br_d = mch_pkg::RESP_SLVERR;
         endcase
      end
      // Bus read; reading a byte or the status has side effects.
      if (rv_q && s_axi_rready) begin
         rv_d = 1'b0;
      end
      if (s_axi_arvalid && !rv_q) begin
         rv_d = 1'b1;
         rr_d = mch_pkg::RESP_OKAY;
         rd_d = 32'h0000_0000;
         case ({s_axi_araddr[7:2], 2'h0})
            mch_pkg::A_CTRL:  rd_d[5:0] = ctrl_q;
            mch_pkg::A_TX0:   rd_d[7:0] = txb_q[0];
            mch_pkg::A_TX1:   rd_d[7:0] = txb_q[1];
            mch_pkg::A_RX0: begin
               rd_d[7:0] = rxb_q[0];
               rdclr[0]  = 1'b1;
            end
            mch_pkg::A_RX1: begin
               rd_d[7:0] = rxb_q[1];
               rdclr[1]  = 1'b1;
            end
            mch_pkg::A_STAT: begin
               rd_d[7:0] = stat_q;
               clr       = clr | stat_q;
            end
            mch_pkg::A_MASK:  rd_d[7:0] = mask_q;
            mch_pkg::A_GSTAT: rd_d[1:0] = act;
            default:          rr_d = mch_pkg::RESP_SLVERR;
         endcase
      end
      unread_d = unread_q & ~rdclr;
      // Frame step; no counter waits on software, so nothing can time out.
      if (done_q) begin
         for (int c = 0; c < 2; c++) begin
            ch_d[c] = mch_pkg::mch_step(ch_q[c],
                         ctrl_q[2*c + mch_pkg::C_TX] & en[c],
                         ctrl_q[2*c + mch_pkg::C_RX] & en[c],
                         unread_q[c],
                         sh_q[c*mch_pkg::CH_STRIDE + mch_pkg::POS_MX] | ~en[c],
                         sh_q[c*mch_pkg::CH_STRIDE + mch_pkg::POS_MR] | ~en[c],
                         ev);
            if (!en[c]) begin
               ev = 4'h0;
            end
            if (ev[mch_pkg::EV_RECV]) begin
               rxb_d[c]    = sh_q[c*mch_pkg::CH_STRIDE +: 8];
               unread_d[c] = 1'b1;
            end
            set[4*c +: 4] = ev;
         end
      end
      // A byte written while transmitting is marked in a later frame.
      for (int c = 0; c < 2; c++) begin
         if (wr && ws_q && ({awa_q[7:2], 2'h0} == (c == 0 ? mch_pkg::A_TX0 : mch_pkg::A_TX1))) begin
            ch_d[c].pend = 1'b1;
         end
      end
      stat_d = (stat_q & ~clr) | set;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q   <= mch_pkg::CTRL_RST;
         txb_q    <= '{8'h00, 8'h00};
         rxb_q    <= '{8'h00, 8'h00};
         stat_q   <= mch_pkg::STAT_RST;
         mask_q   <= mch_pkg::MASK_RST;
         unread_q <= 2'h0;
         ch_q     <= '{mch_pkg::CHAN_RST, mch_pkg::CHAN_RST};
         idx_q    <= 5'h0;
         sh_q     <= 24'hFF_FFFF;
         done_q   <= 1'b0;
         dn_q     <= 1'b1;
         aw_q     <= 1'b0;
         awa_q    <= 8'h00;
         w_q      <= 1'b0;
         wd_q     <= 32'h0000_0000;
         ws_q     <= 1'b0;
         bv_q     <= 1'b0;
         br_q     <= mch_pkg::RESP_OKAY;
         rv_q     <= 1'b0;
         rd_q     <= 32'h0000_0000;
         rr_q     <= mch_pkg::RESP_OKAY;
      end else begin
         ctrl_q   <= ctrl_d;
         txb_q    <= txb_d;
         rxb_q    <= rxb_d;
         stat_q   <= stat_d;
         mask_q   <= mask_d;
         unread_q <= unread_d;
         ch_q     <= ch_d;
         idx_q    <= idx_d;
         sh_q     <= sh_d;
         done_q   <= done_d;
         dn_q     <= dn_d;
         aw_q     <= aw_d;
         awa_q    <= awa_d;
         w_q      <= w_d;
         wd_q     <= wd_d;
         ws_q     <= ws_d;
         bv_q     <= bv_d;
         br_q     <= br_d;
         rv_q     <= rv_d;
         rd_q     <= rd_d;
         rr_q     <= rr_d;
      end
   end

   assign s_axi_awready = ~aw_q;
   assign s_axi_wready  = ~w_q;
   assign s_axi_bvalid  = bv_q;
   assign s_axi_bresp   = br_q;
   assign s_axi_arready = ~rv_q;
   assign s_axi_rvalid  = rv_q;
   assign s_axi_rdata   = rd_q;
   assign s_axi_rresp   = rr_q;
   assign link.dn       = dn_q;
   // Unmasked data-received always reaches the line; the rest only once enabled.
   assign irq = |(stat_q & mask_q &
                  (ctrl_q[mch_pkg::C_IEN] ? 8'hFF : mch_pkg::RECV_ONLY));

endmodule // mch_dev
`default_nettype wire

// File: mch_link_if.sv
// Purpose: Backplane link between the monitor controller and its peer.
// Assumes: The peer makes the link clock and frame sync.
// Notes:   All four wires are plain one-way signals.
`timescale 1ns/1ps
`default_nettype none
interface mch_link_if;
   logic lclk;
   logic fsync;
   logic dn;
   logic up;

   modport dev  (input lclk, input fsync, input up, output dn);
   modport peer (output lclk, output fsync, output up, input dn);
endinterface
`default_nettype wire

// File: mch_peer.sv
// Purpose: Peer end of the monitor channel link with a plain user port.
// Assumes: This end makes the link clock by dividing clk and frames it.
// Notes:   The written byte goes out as is; change it only between handshakes.
`timescale 1ns/1ps
`default_nettype none
module mch_peer (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // User control
   input  wire logic [1:0]  tx_on,
   input  wire logic [1:0]  rx_on,
   input  wire logic [15:0] tx_byte,
   input  wire logic [1:0]  tx_load,
   input  wire logic [1:0]  rx_read,
   // User status
   output logic [15:0]      rx_byte,
   output logic [1:0]       rx_got,
   output logic [1:0]       acked,
   output logic [1:0]       rx_end,
   output logic [1:0]       aborted,
   output logic [1:0]       active,
   // Backplane link
   mch_link_if.peer         link
);

   logic               dn1_q;
   logic               dn2_q;
   logic [3:0]         div_q, div_d;
   logic               lclk_q, lclk_d;
   logic               fs_q, fs_d;
   logic               up_q, up_d;
   logic [4:0]         bit_q, bit_d;
   logic [23:0]        sh_q, sh_d;
   logic [23:0]        ofr;
   logic               done_q, done_d;
   logic [15:0]        txb_q, txb_d;
   logic [15:0]        rxb_q, rxb_d;
   logic [1:0]         unread_q, unread_d;
   logic [7:0]         ev_q, ev_d;
   mch_pkg::mch_chan_s ch_q [2];
   mch_pkg::mch_chan_s ch_d [2];

   // The returned data comes from the other end's domain.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dn1_q <= 1'b1;
         dn2_q <= 1'b1;
      end else begin
         dn1_q <= link.dn;
         dn2_q <= dn1_q;
      end
   end

   always_comb begin
      ofr = 24'hFF_FFFF;
      for (int c = 0; c < 2; c++) begin
         ofr[c*mch_pkg::CH_STRIDE +: 8]              = txb_q[8*c +: 8];
         ofr[c*mch_pkg::CH_STRIDE + mch_pkg::POS_MX] = ch_q[c].mx;
         ofr[c*mch_pkg::CH_STRIDE + mch_pkg::POS_MR] = ch_q[c].mr;
         active[c] = ~ch_q[c].mx | ~ch_q[c].mr | ch_q[c].busy;
      end
   end

   always_comb begin
      logic [3:0] ev;
      ev       = 4'h0;
      div_d    = div_q + 4'h1;
      lclk_d   = lclk_q;
      fs_d     = fs_q;
      up_d     = up_q;
      bit_d    = bit_q;
      sh_d     = sh_q;
      done_d   = 1'b0;
      txb_d    = txb_q;
      rxb_d    = rxb_q;
      unread_d = unread_q & ~rx_read;
      ev_d     = 8'h00;
      ch_d     = ch_q;
      // Divided link clock; data moves on the fall, is sampled on the rise.
      if (div_q == mch_pkg::LCLK_HALF_M1) begin
         div_d  = 4'h0;
         lclk_d = ~lclk_q;
         if (lclk_q) begin
            bit_d = (bit_q == mch_pkg::LAST_BIT) ? 5'h0 : bit_q + 5'h1;
            up_d  = ofr[bit_d];
            fs_d  = (bit_d == 5'h0);
         end else begin
            sh_d[bit_q] = dn2_q;
            done_d      = (bit_q == mch_pkg::LAST_BIT);
         end
      end
      if (done_q) begin
         for (int c = 0; c < 2; c++) begin
            ch_d[c] = mch_pkg::mch_step(ch_q[c], tx_on[c], rx_on[c], unread_q[c],
                         sh_q[c*mch_pkg::CH_STRIDE + mch_pkg::POS_MX],
                         sh_q[c*mch_pkg::CH_STRIDE + mch_pkg::POS_MR], ev);
            if (ev[mch_pkg::EV_RECV]) begin
               rxb_d[8*c +: 8] = sh_q[c*mch_pkg::CH_STRIDE +: 8];
               unread_d[c]     = 1'b1;
            end
            ev_d[4*c +: 4] = ev;
         end
      end
      for (int c = 0; c < 2; c++) begin
         if (tx_load[c]) begin
            txb_d[8*c +: 8] = tx_byte[8*c +: 8];
            ch_d[c].pend    = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_q    <= 4'h0;
         lclk_q   <= 1'b0;
         fs_q     <= 1'b0;
         up_q     <= 1'b1;
         bit_q    <= mch_pkg::LAST_BIT;
         sh_q     <= 24'hFF_FFFF;
         done_q   <= 1'b0;
         txb_q    <= 16'h0000;
         rxb_q    <= 16'h0000;
         unread_q <= 2'h0;
         ev_q     <= 8'h00;
         ch_q     <= '{mch_pkg::CHAN_RST, mch_pkg::CHAN_RST};
      end else begin
         div_q    <= div_d;
         lclk_q   <= lclk_d;
         fs_q     <= fs_d;
         up_q     <= up_d;
         bit_q    <= bit_d;
         sh_q     <= sh_d;
         done_q   <= done_d;
         txb_q    <= txb_d;
         rxb_q    <= rxb_d;
         unread_q <= unread_d;
         ev_q     <= ev_d;
         ch_q     <= ch_d;
      end
   end

   assign link.lclk  = lclk_q;
   assign link.fsync = fs_q;
   assign link.up    = up_q;
   assign rx_byte    = rxb_q;
   assign rx_got     = {ev_q[4 + mch_pkg::EV_RECV],  ev_q[mch_pkg::EV_RECV]};
   assign acked      = {ev_q[4 + mch_pkg::EV_ACK],   ev_q[mch_pkg::EV_ACK]};
   assign rx_end     = {ev_q[4 + mch_pkg::EV_END],   ev_q[mch_pkg::EV_END]};
   assign aborted    = {ev_q[4 + mch_pkg::EV_ABORT], ev_q[mch_pkg::EV_ABORT]};

endmodule // mch_peer
`default_nettype wire

// File: mch_pkg.sv
// Purpose: Shared constants, channel state and frame step of the monitor channel handshake.
// Assumes: A frame of 24 link bits, framed by the frame sync on bit 0.
// Notes:   Both ends call the same frame step, so they keep the same protocol.
package mch_pkg;

   // Link frame layout.
   localparam int unsigned FRAME_BITS = 24;
   localparam logic [4:0]  LAST_BIT   = 5'h17;
   localparam int unsigned NCH        = 2;
   localparam int unsigned CH_STRIDE  = 10;
   localparam int unsigned POS_MX     = 8;
   localparam int unsigned POS_MR     = 9;

   // Synchroniser bit positions on the device end.
   localparam int unsigned L_CLK = 0;
   localparam int unsigned L_FS  = 1;
   localparam int unsigned L_DAT = 2;

   // Link clock divider on the peer end: half period in clk cycles, less one.
   localparam logic [3:0] LCLK_HALF_M1 = 4'h7;

   // Register byte addresses.
   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_TX0   = 8'h04;
   localparam logic [7:0] A_TX1   = 8'h08;
   localparam logic [7:0] A_RX0   = 8'h0C;
   localparam logic [7:0] A_RX1   = 8'h10;
   localparam logic [7:0] A_STAT  = 8'h14;
   localparam logic [7:0] A_MASK  = 8'h18;
   localparam logic [7:0] A_GSTAT = 8'h1C;

   // Control register fields; transmit and receive bits of channel c sit at 2*c and 2*c+1.
   localparam int unsigned C_TX   = 0;
   localparam int unsigned C_RX   = 1;
   localparam int unsigned C_IEN  = 4;
   localparam int unsigned C_TERM = 5;
   localparam logic [5:0]  CTRL_RST = 6'h00;

   // Event and status layout; channel c uses bits 4*c+3 .. 4*c.
   localparam int unsigned EV_RECV  = 0;
   localparam int unsigned EV_ACK   = 1;
   localparam int unsigned EV_END   = 2;
   localparam int unsigned EV_ABORT = 3;
   localparam logic [7:0]  RECV_ONLY = 8'h11;
   localparam logic [7:0]  STAT_RST  = 8'h00;
   localparam logic [7:0]  MASK_RST  = 8'h00;

   // Bus answers.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic mx;        // Transmit-valid bit sent, active low.
      logic wait_ack;  // Byte sent and not yet acknowledged.
      logic pend;      // New byte written, waiting to be marked.
      logic seen_ack;  // Receiver has acknowledged at least once.
      logic mr_in_p;   // Acknowledge bit seen in the previous frame.
      logic mr;        // Acknowledge bit sent, active low.
      logic need_ack;  // Received byte still to be acknowledged.
      logic mx_in_p;   // Transmit-valid bit seen in the previous frame.
      logic busy;      // A message is being received.
   } mch_chan_s;

   localparam mch_chan_s CHAN_RST = '{mx: 1'b1, wait_ack: 1'b0, pend: 1'b0, seen_ack: 1'b0,
                                      mr_in_p: 1'b1, mr: 1'b1, need_ack: 1'b0,
                                      mx_in_p: 1'b1, busy: 1'b0};

   // One frame of both halves of a channel.
   function automatic mch_chan_s mch_step(input mch_chan_s s, input logic tx_on,
                                          input logic rx_on, input logic unread,
                                          input logic mx_in, input logic mr_in,
                                          output logic [3:0] ev);
      mch_chan_s n;
      n  = s;
      ev = 4'h0;
      if (!tx_on) begin
         n.mx       = 1'b1;
         n.wait_ack = 1'b0;
         n.pend     = 1'b0;
         n.seen_ack = 1'b0;
      end else if (s.mx) begin
         n.mx       = 1'b0;
         n.wait_ack = 1'b1;
         n.pend     = 1'b0;
      end else if (s.pend && !s.wait_ack) begin
         n.mx = 1'b1;
      end
      if (tx_on && s.wait_ack && s.mr_in_p && !mr_in) begin
         n.wait_ack   = 1'b0;
         n.seen_ack   = 1'b1;
         ev[EV_ACK]   = 1'b1;
      end
      if (tx_on && s.seen_ack && s.mr_in_p && mr_in) begin
         n.seen_ack   = 1'b0;
         ev[EV_ABORT] = 1'b1;
      end
      n.mr_in_p = mr_in;
      if (s.mx_in_p && !mx_in) begin
         n.need_ack  = 1'b1;
         n.busy      = 1'b1;
         ev[EV_RECV] = 1'b1;
      end
      if (s.busy && s.mx_in_p && mx_in) begin
         n.busy     = 1'b0;
         n.need_ack = 1'b0;
         ev[EV_END] = 1'b1;
      end
      n.mx_in_p = mx_in;
      if (!rx_on) begin
         n.mr = 1'b1;
      end else if (s.need_ack && !unread) begin
         n.mr = ~s.mr;
         if (s.mr) begin
            n.need_ack = 1'b0;
         end
      end
      return n;
   endfunction

endpackage

// File: mch_props.sv
// Purpose: Wire checks on the link between the monitor controller and its peer.
// Assumes: The peer makes lclk with 8 clk high and 8 clk low, in frames of 24 bits.
// Notes:   The bit count parks at 31 until the first frame sync, so no check fires early.
`timescale 1ns/1ps
`default_nettype none
module mch_props (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Link wires
   input wire logic lclk,
   input wire logic fsync,
   input wire logic dn,
   input wire logic up
);
   logic [4:0] bit_q;
   logic [4:0] bit_d;
   logic       lclk_q;

   always_comb begin
      bit_d = bit_q;
      if (lclk && !lclk_q) begin
         bit_d = fsync ? 5'h00 : ((bit_q == 5'h1f) ? bit_q : bit_q + 5'h01);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bit_q  <= 5'h1f;
         lclk_q <= 1'b0;
      end else begin
         bit_q  <= bit_d;
         lclk_q <= lclk;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_lhi; $rose(lclk) |-> lclk[*8] ##1 !lclk; endproperty
   property p_llo; $fell(lclk) |-> (!lclk)[*8] ##1 lclk; endproperty
   property p_fs; $rose(fsync) |-> ##15 fsync ##1 !fsync; endproperty
   property p_frame; $rose(lclk) && fsync && bit_q != 5'h1f |-> bit_q == 5'h17; endproperty
   property p_tail; $rose(lclk) && bit_q inside {[5'h13:5'h16]} |-> dn && up; endproperty
   property p_rst; $rose(rst_b) |-> dn; endproperty
   property p_dnset; $changed(dn) |-> !lclk; endproperty
   property p_upset; $changed(up) || $changed(fsync) |-> !lclk; endproperty

   a_lhi: assert property (p_lhi) else $error("Link clock high phase wrong");
   a_llo: assert property (p_llo) else $error("Link clock low phase wrong");
   a_fs: assert property (p_fs) else $error("Frame sync width wrong");
   a_frame: assert property (p_frame) else $error("Frame length wrong");
   a_tail: assert property (p_tail) else $error("Spare bits not idle");
   a_rst: assert property (p_rst) else $error("Device line not idle after reset");
   a_dnset: assert property (p_dnset) else $error("Device data moved while clock high");
   a_upset: assert property (p_upset) else $error("Peer data moved while clock high");

   c_mx: cover property ($rose(lclk) && bit_q == 5'h07 && !dn);
   c_pmx: cover property ($rose(lclk) && bit_q == 5'h07 && !up);
   c_ack: cover property ($rose(lclk) && bit_q == 5'h08 && !up);
endmodule // mch_props
`default_nettype wire

// File: monitor_channel_handshake_bench.sv
// Purpose: Bench with the controller and its peer facing each other on one link.
// Assumes: A frame lasts 384 clk; every wait is bounded.
// Notes:   Channel 1 stays idle, so only channel 0 traffic is judged.
`timescale 1ns/1ps
`default_nettype none
module monitor_channel_handshake_bench;
   logic        clk, rst_b, irq;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, tx_on, rx_on, tx_load, rx_read;
   logic [1:0]  rx_got, acked, rx_end, aborted, active;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [15:0] tx_byte, rx_byte;
   int          fails, cmp_count;

   mch_link_if link ();
   mch_dev u_mch_dev (.*);
   mch_peer u_mch_peer (.*);
   mch_props u_mch_props (.clk, .rst_b, .lclk(link.lclk), .fsync(link.fsync),
                          .dn(link.dn), .up(link.up));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic wrap_up;
      $display("Compares %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er, input logic [31:0] ed);
      int n;
      @(posedge clk);
      if (wr) begin
         {s_axi_awaddr, s_axi_wdata} <= {a, d};
         {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      end else begin
         s_axi_araddr <= a;
         {s_axi_arvalid, s_axi_rready} <= 2'h3;
      end
      n = 0;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_bvalid) begin
            s_axi_bready <= 1'b0;
            chk({30'h0, s_axi_bresp}, {30'h0, er});
         end
         if (s_axi_rvalid) begin
            s_axi_rready <= 1'b0;
            chk({30'h0, s_axi_rresp}, {30'h0, er});
            chk(s_axi_rdata, ed);
         end
         n++;
      end while (n < 50 && (s_axi_bready || s_axi_rready));
      if (n == 50) begin
         chk(32'h1, 32'h0);
         wrap_up;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, mch_pkg::RESP_OKAY, 32'h0);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, mch_pkg::RESP_OKAY, e);
   endtask

   task automatic wait_ev(input int k);
      int n;
      logic [4:0] ev;
      for (n = 0; n < 3000; n++) begin
         @(posedge clk);
         #1;
         ev = {irq, aborted[0], rx_end[0], acked[0], rx_got[0]};
         if (ev[k] === 1'b1) break;
      end
      if (n == 3000) begin
         chk(32'h1, 32'h0);
         wrap_up;
      end
   endtask

   task automatic drv(input logic [1:0] txo, input logic [1:0] rxo, input logic ld,
                      input logic rdp);
      @(posedge clk);
      {tx_on, rx_on, tx_load, rx_read} <= {txo, rxo, 1'b0, ld, 1'b0, rdp};
      @(posedge clk);
      {tx_load, rx_read} <= 4'h0;
   endtask

   task automatic t_regs;
      rdc(mch_pkg::A_CTRL, 32'h0);
      rdc(mch_pkg::A_STAT, 32'h0);
      rdc(mch_pkg::A_GSTAT, 32'h0);
      bus(1'b0, 8'h20, 32'h0, mch_pkg::RESP_SLVERR, 32'h0);
      bus(1'b1, 8'h24, 32'h1, mch_pkg::RESP_SLVERR, 32'h0);
      wr(mch_pkg::A_CTRL, 32'h20);
      rdc(mch_pkg::A_CTRL, 32'h20);
      chk({31'h0, irq}, 32'h0);
      $display("Test regs done");
   endtask

   task automatic t_send;
      wr(mch_pkg::A_MASK, 32'hff);
      wr(mch_pkg::A_TX0, 32'ha5);
      wr(mch_pkg::A_CTRL, 32'h11);
      wait_ev(0);
      chk({24'h0, rx_byte[7:0]}, 32'ha5);
      drv(2'h0, 2'h1, 1'b0, 1'b1);
      wait_ev(4);
      rdc(mch_pkg::A_STAT, 32'h2);
      chk({31'h0, irq}, 32'h0);
      wr(mch_pkg::A_TX0, 32'h3c);
      wait_ev(0);
      chk({24'h0, rx_byte[7:0]}, 32'h3c);
      drv(2'h0, 2'h1, 1'b0, 1'b1);
      wait_ev(4);
      rdc(mch_pkg::A_STAT, 32'h2);
      wr(mch_pkg::A_CTRL, 32'h10);
      wait_ev(2);
      drv(2'h0, 2'h0, 1'b0, 1'b0);
      rdc(mch_pkg::A_GSTAT, 32'h0);
      $display("Test send done");
   endtask

   task automatic t_recv;
      drv(2'h1, 2'h0, 1'b1, 1'b0);
      wait_ev(4);
      rdc(mch_pkg::A_STAT, 32'h1);
      rdc(mch_pkg::A_RX0, 32'h5a);
      rdc(mch_pkg::A_GSTAT, 32'h1);
      chk({30'h0, active}, 32'h1);
      wr(mch_pkg::A_CTRL, 32'h12);
      wait_ev(1);
      wr(mch_pkg::A_CTRL, 32'h10);
      wait_ev(3);
      drv(2'h0, 2'h0, 1'b0, 1'b0);
      $display("Test receive done");
   endtask

   initial begin
      {fails, cmp_count, rst_b, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {tx_on, rx_on, tx_load, rx_read} = '0;
      s_axi_wstrb = 4'hf;
      tx_byte = 16'h005a;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      t_regs;
      t_send;
      t_recv;
      wrap_up;
   end
endmodule // monitor_channel_handshake_bench
`default_nettype wire
